// *** design/tcap_timer.v ***
// Sixteen-bit down timer with input capture mode and APB register access
`timescale 1ns/1ns
`default_nettype none

`include "tcap_map.vh"

// How it works
// - Capture mode decrements the timer once per instruction clock tick.
// - In capture mode a selected edge on the timer pin copies the count into the capture register.
// - Edge polarity bit picks rising or falling capture edge.
// - Polarity may change while counting; count and mode stay undisturbed.
// - Capture or underflow raise the single timer interrupt when enabled.
// - In capture mode underflow sets the run bit, used as underflow flag.
// - A capture sets the capture pending flag.
// - Capture and underflow together set both flags.
// - Counting starts on entering capture mode and runs while it stays selected.
// - Other modes with run bit clear hold the timer still.
// - Interrupt goes out only with timer enable and global enable both set.
// - Mode bits 0,1,0 capture rising edges; 0,1,1 capture falling edges.
// - Control holds mode and run in bits 7..4, pending 3, enable 2.
module tcap_timer
(
  input  wire                     core_clk,   // Core clock, 50 MHz
  input  wire                     rst,        // Async reset, active high
  input  wire                     psel,       // APB select
  input  wire                     penable,    // APB access phase
  input  wire                     pwrite,     // APB write when high
  input  wire [`TCAP_ADDR_W-1:0]  paddr,      // APB byte address
  input  wire [31:0]              pwdata,     // APB write data
  output reg  [31:0]              prdata,     // APB read data
  output reg                      pready,     // APB ready
  output reg                      pslverr,    // APB error, unmapped address
  input  wire                     timer_pin,  // Timer pin input level
  output reg                      timer_irq   // Timer interrupt request to CPU
);

  // Control fields
  reg                     mode_select_high;
  reg                     mode_select_mid;
  reg                     edge_polarity_select;
  reg                     run_or_underflow_flag;
  reg                     capture_pending_flag;
  reg                     timer_irq_enable;
  reg                     global_irq_enable;
  reg [`TCAP_CNT_W-1:0]   timer_count;
  reg [`TCAP_CNT_W-1:0]   capture_reload_reg;
  reg [`TCAP_DIV_W-1:0]   div_count;
  reg                     tick;

  wire                    pin_rise;
  wire                    pin_fall;

  function is_mode;
    input       hi;
    input       mid;
    input [1:0] code;
    begin
      is_mode = ({hi, mid} == code);
    end
  endfunction

  function addr_hit;
    input [`TCAP_ADDR_W-1:0] addr;
    input [`TCAP_ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  function is_reg;
    input [`TCAP_ADDR_W-1:0] addr;
    begin
      is_reg = addr_hit(addr, `TCAP_OFS_CTRL) || addr_hit(addr, `TCAP_OFS_COUNT) ||
               addr_hit(addr, `TCAP_OFS_CAPTURE) || addr_hit(addr, `TCAP_OFS_GLOBAL);
    end
  endfunction

  wire capture_mode = is_mode(mode_select_high, mode_select_mid, `TCAP_MODE_CAPTURE);
  wire pwm_mode     = is_mode(mode_select_high, mode_select_mid, `TCAP_MODE_PWM);
  wire event_mode   = is_mode(mode_select_high, mode_select_mid, `TCAP_MODE_EVENT);

  wire setup_phase  = psel & ~penable;
  wire access_done  = psel & penable & pready;
  // Writes land only at the access edge, never at setup
  wire wr_access    = access_done & pwrite;
  wire wr_ctrl      = wr_access & addr_hit(paddr, `TCAP_OFS_CTRL);
  wire wr_count     = wr_access & addr_hit(paddr, `TCAP_OFS_COUNT);
  wire wr_capture   = wr_access & addr_hit(paddr, `TCAP_OFS_CAPTURE);
  wire wr_global    = wr_access & addr_hit(paddr, `TCAP_OFS_GLOBAL);

  // Instruction clock enable, one core cycle in every fifty
  // Divider starts at zero, so the first tick comes fifty cycles after reset
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_count <= `TCAP_DIV_ZERO;
      tick      <= 1'b0;
    end
    else if (div_count == `TCAP_DIV_LAST)
    begin
      div_count <= `TCAP_DIV_ZERO;
      tick      <= 1'b1;
    end
    else
    begin
      div_count <= div_count + `TCAP_DIV_ONE;
      tick      <= 1'b0;
    end
  end

  tcap_pin_edge u_pin_edge
  (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick),
    .pin_in   (timer_pin),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  // Selected edge; polarity bit is read live so it may change mid-count
  wire sel_edge = edge_polarity_select ? pin_fall : pin_rise;

  // Count step: capture mode on every tick, PWM on ticks with run, event on pin edges with run
  wire count_step = capture_mode ? tick :
                    (run_or_underflow_flag &
                     ((pwm_mode & tick) | (event_mode & sel_edge)));
  wire at_zero    = (timer_count == `TCAP_CNT_ZERO);
  wire underflow  = count_step & at_zero;
  wire capture    = capture_mode & sel_edge;
  wire reload     = underflow & ~capture_mode;

  // Timer register; a software write overrides the step in the same cycle
  reg [`TCAP_CNT_W-1:0]   next_timer_count;

  always @*
  begin
    next_timer_count = timer_count;
    if (wr_count)
    begin
      next_timer_count = pwdata[`TCAP_CNT_W-1:0];
    end
    else if (reload)
    begin
      next_timer_count = capture_reload_reg;
    end
    else if (count_step)
    begin
      // Capture mode wraps through zero to all ones, with no reload
      next_timer_count = timer_count - `TCAP_CNT_ONE;
    end
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_count <= `TCAP_CNT_RESET;
    end
    else
    begin
      timer_count <= next_timer_count;
    end
  end

  // Capture wins over a software write landing in the same cycle
  reg [`TCAP_CNT_W-1:0]   next_capture;

  always @*
  begin
    next_capture = capture_reload_reg;
    if (capture)
    begin
      // Count before this tick's decrement is what gets captured
      next_capture = timer_count;
    end
    else if (wr_capture)
    begin
      next_capture = pwdata[`TCAP_CNT_W-1:0];
    end
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      capture_reload_reg <= `TCAP_CAP_RESET;
    end
    else
    begin
      capture_reload_reg <= next_capture;
    end
  end

  // Configuration fields of the control register; only a control write moves them
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_select_high     <= 1'b0;
      mode_select_mid      <= 1'b0;
      edge_polarity_select <= 1'b0;
      timer_irq_enable     <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      mode_select_high     <= pwdata[`TCAP_BIT_MODE_HIGH];
      mode_select_mid      <= pwdata[`TCAP_BIT_MODE_MID];
      edge_polarity_select <= pwdata[`TCAP_BIT_EDGE_POL];
      timer_irq_enable     <= pwdata[`TCAP_BIT_IRQ_EN];
    end
  end

  // Global enable stands in for the CPU status bit
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      global_irq_enable <= `TCAP_GLOBAL_RESET;
    end
    else if (wr_global)
    begin
      global_irq_enable <= pwdata[`TCAP_BIT_GLOBAL_EN];
    end
  end

  // Underflow flag in capture mode, run control elsewhere; a set beats a clear
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      run_or_underflow_flag <= 1'b0;
    end
    else if (capture_mode & underflow)
    begin
      run_or_underflow_flag <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      run_or_underflow_flag <= pwdata[`TCAP_BIT_RUN_UFL];
    end
  end

  // Capture in capture mode, reload in the other modes; a set beats a clear
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      capture_pending_flag <= 1'b0;
    end
    else if (capture | reload)
    begin
      capture_pending_flag <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      capture_pending_flag <= pwdata[`TCAP_BIT_PEND];
    end
  end

  // Interrupt request: run bit counts as a source only in capture mode
  wire irq_source = capture_pending_flag | (capture_mode & run_or_underflow_flag);

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_irq <= 1'b0;
    end
    else
    begin
      // Registered, so the request reaches the CPU one cycle after the flag
      timer_irq <= irq_source & timer_irq_enable & global_irq_enable;
    end
  end

  // Read mux; reserved control bits read as zero
  reg [31:0] next_prdata;

  always @*
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      `TCAP_OFS_CTRL:
      begin
        next_prdata[`TCAP_BIT_MODE_HIGH] = mode_select_high;
        next_prdata[`TCAP_BIT_MODE_MID]  = mode_select_mid;
        next_prdata[`TCAP_BIT_EDGE_POL]  = edge_polarity_select;
        next_prdata[`TCAP_BIT_RUN_UFL]   = run_or_underflow_flag;
        next_prdata[`TCAP_BIT_PEND]      = capture_pending_flag;
        next_prdata[`TCAP_BIT_IRQ_EN]    = timer_irq_enable;
      end
      `TCAP_OFS_COUNT:
      begin
        next_prdata[`TCAP_CNT_W-1:0] = timer_count;
      end
      `TCAP_OFS_CAPTURE:
      begin
        next_prdata[`TCAP_CNT_W-1:0] = capture_reload_reg;
      end
      `TCAP_OFS_GLOBAL:
      begin
        next_prdata[`TCAP_BIT_GLOBAL_EN] = global_irq_enable;
      end
      default:
      begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // Zero-wait APB: ready is raised at the setup edge, so the first access
  // edge completes. Read data is captured at setup and may be one cycle
  // older than the access edge; a count read is thus up to one core cycle stale.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup_phase;
      pslverr <= setup_phase & ~is_reg(paddr);
      // Unmapped addresses answer with an error and touch no register
      if (setup_phase)
      begin
        prdata <= next_prdata;
      end
    end
  end

endmodule

`default_nettype wire

// *** design/tcap_map.vh ***
// Register map, field positions, reset values and timing for the capture timer
`ifndef TCAP_MAP_VH
`define TCAP_MAP_VH

// APB byte addresses
`define TCAP_ADDR_W          12
`define TCAP_OFS_CTRL        12'h000
`define TCAP_OFS_COUNT       12'h004
`define TCAP_OFS_CAPTURE     12'h008
`define TCAP_OFS_GLOBAL      12'h00C

// Control register fields
`define TCAP_BIT_MODE_HIGH   7
`define TCAP_BIT_MODE_MID    6
`define TCAP_BIT_EDGE_POL    5
`define TCAP_BIT_RUN_UFL     4
`define TCAP_BIT_PEND        3
`define TCAP_BIT_IRQ_EN      2
`define TCAP_CTRL_W          8
`define TCAP_CTRL_RESET      8'h00

// Mode field values: high and mid mode bits
`define TCAP_MODE_EVENT      2'h0
`define TCAP_MODE_CAPTURE    2'h1
`define TCAP_MODE_PWM        2'h2

// Global enable register
`define TCAP_BIT_GLOBAL_EN   0
`define TCAP_GLOBAL_RESET    1'h0

// Timer and capture registers
`define TCAP_CNT_W           16
`define TCAP_CNT_ZERO        16'h0000
`define TCAP_CNT_ONE         16'h0001
`define TCAP_CNT_RESET       16'hFFFF
`define TCAP_CAP_RESET       16'h0000

// Instruction clock derived from the core clock
`define TCAP_CLK_NS          20
`define TCAP_INSTR_NS        1000
`define TCAP_TICK_CYCLES     (`TCAP_INSTR_NS / `TCAP_CLK_NS)
`define TCAP_DIV_W           6
`define TCAP_DIV_ZERO        6'h00
`define TCAP_DIV_ONE         6'h01
// Last divider count, one below the tick period
`define TCAP_DIV_LAST        6'h31

`endif

// *** design/tcap_pin_edge.v ***
// Timer pin synchroniser and instruction-tick edge detector
`timescale 1ns/1ns
`default_nettype none

module tcap_pin_edge
(
  input  wire core_clk,   // Core clock
  input  wire rst,        // Async reset, active high
  input  wire tick,       // Instruction clock enable
  input  wire pin_in,     // Raw timer pin level
  output wire rise,       // Rising edge seen, one tick pulse
  output wire fall        // Falling edge seen, one tick pulse
);

  reg sync_a;
  reg sync_b;
  reg sample;
  reg primed;

  // Only sync_b is looked at past the first stage
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sample <= 1'b0;
      primed <= 1'b0;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      if (tick)
      begin
        sample <= sync_b;
        primed <= 1'b1;
      end
    end
  end

  // First tick after reset only loads the sample, so a high pin is no edge
  assign rise = tick & primed & sync_b & ~sample;
  assign fall = tick & primed & ~sync_b & sample;

endmodule

`default_nettype wire

// *** verification/tcap_chk_assertions.sv ***
// Port-level checks for the capture timer
`timescale 1ns/1ns
`default_nettype none
`include "tcap_map.vh"
module tcap_chk
(
  input wire logic        core_clk,  // Clock
  input wire logic        rst,       // Reset
  input wire logic        psel,      // Select
  input wire logic        penable,   // Access
  input wire logic        pwrite,    // Write
  input wire logic [11:0] paddr,     // Address
  input wire logic [31:0] pwdata,    // Wdata
  input wire logic [31:0] prdata,    // Rdata
  input wire logic        pready,    // Ready
  input wire logic        pslverr,   // Error
  input wire logic        timer_pin, // Pin
  input wire logic        timer_irq  // Irq
);
  default clocking dck @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no ready");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("long ready");
  AST_UNMAP: assert property
    (psel && !penable && paddr > `TCAP_OFS_GLOBAL |=> pslverr && prdata == 32'h0)
    else $error("unmapped accepted");
  AST_MAPPED: assert property
    (psel && !penable && paddr[1:0] == 2'h0 && paddr <= `TCAP_OFS_GLOBAL |=> !pslverr)
    else $error("mapped refused");
  AST_IRQ_RST: assert property ($fell(rst) |-> !timer_irq)
    else $error("irq after reset");
  AST_IRQ_EN: assert property
    (psel && penable && pready && pwrite && paddr == `TCAP_OFS_CTRL
     && !pwdata[`TCAP_BIT_IRQ_EN] |-> ##2 !timer_irq)
    else $error("irq while disabled");
  AST_IRQ_GLB: assert property
    (psel && penable && pready && pwrite && paddr == `TCAP_OFS_GLOBAL
     && !pwdata[`TCAP_BIT_GLOBAL_EN] |-> ##2 !timer_irq)
    else $error("irq while global off");
  AST_IRQ_HOLD: assert property
    (timer_irq && !$past(psel && penable && pready && pwrite) |=> timer_irq)
    else $error("irq dropped alone");
endmodule
`default_nettype wire

// *** verification/tcap_pin_src.sv ***
// Behavioural source driving the timer pin
`timescale 1ns/1ns
`default_nettype none
module tcap_pin_src #(parameter int HOLD = 50)
(
  input  wire logic core_clk,  // Clock
  input  wire logic rst,       // Reset
  input  wire logic lvl_req,   // Level asked by bench
  output var  logic timer_pin  // Pin, input only at timer
);
  int held;
  // Each level held a full instruction cycle
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      timer_pin <= 1'b0;
      held <= HOLD;
    end
    else if (lvl_req != timer_pin && held >= HOLD)
    begin
      timer_pin <= lvl_req;
      held <= 0;
    end
    else if (held < HOLD)
      held <= held + 1;
  end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Directed bench for the capture timer
`timescale 1ns/1ns
`default_nettype none
`include "tcap_map.vh"
module testbench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, timer_pin, timer_irq;
  logic        lvl = 1'b0;
  logic        err;
  logic [31:0] r, c1;
  int          bad_count = 0;
  int          checks = 0;
  int          cyc = 0;
  int          t0;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  tcap_timer uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_pin(timer_pin), .timer_irq(timer_irq));
  tcap_pin_src src (.core_clk(core_clk), .rst(rst), .lvl_req(lvl), .timer_pin(timer_pin));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Starts and ends just after a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20)
      bad_count++;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task wait_to(input int t);
    while (cyc < t)
      @(posedge core_clk);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Whole run is about 3400 cycles
  initial
  begin
    #400000;
    bad_count++;
    wrap_up;
  end
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'h0, `TCAP_OFS_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'h0, `TCAP_OFS_COUNT, 32'h0);
    chk(r, 32'hFFFF);
    apb(1'h0, 12'h010, 32'h0);
    chk(err, 32'h1);
    apb(1'h1, `TCAP_OFS_CTRL, 32'h0);
    apb(1'h1, `TCAP_OFS_COUNT, 32'h1234);
    repeat (300) @(posedge core_clk);
    apb(1'h0, `TCAP_OFS_COUNT, 32'h0);
    chk(r, 32'h1234);
    $display("reset, map and hold done");
    apb(1'h1, `TCAP_OFS_GLOBAL, 32'h1);
    apb(1'h1, `TCAP_OFS_COUNT, 32'hFFFF);
    apb(1'h1, `TCAP_OFS_CTRL, 32'h44);
    t0 = cyc;
    apb(1'h0, `TCAP_OFS_COUNT, 32'h0);
    c1 = r;
    wait_to(t0 + 500);
    apb(1'h0, `TCAP_OFS_COUNT, 32'h0);
    chk(c1 - r, 32'hA);
    $display("counting done");
    t0 = cyc;
    lvl <= 1'b1;
    wait_to(t0 + 200);
    apb(1'h0, `TCAP_OFS_CTRL, 32'h0);
    chk(r, 32'h4C);
    chk(timer_irq, 32'h1);
    apb(1'h0, `TCAP_OFS_CAPTURE, 32'h0);
    c1 = r;
    apb(1'h1, `TCAP_OFS_CTRL, 32'h64);
    wait_to(t0 + 1000);
    lvl <= 1'b0;
    wait_to(t0 + 1200);
    apb(1'h0, `TCAP_OFS_CAPTURE, 32'h0);
    chk(c1 - r, 32'h14);
    c1 = r;
    apb(1'h1, `TCAP_OFS_CTRL, 32'h64);
    lvl <= 1'b1;
    wait_to(t0 + 1500);
    apb(1'h0, `TCAP_OFS_CTRL, 32'h0);
    chk(r, 32'h64);
    apb(1'h0, `TCAP_OFS_CAPTURE, 32'h0);
    chk(r, c1);
    $display("capture done");
    apb(1'h1, `TCAP_OFS_CTRL, 32'h44);
    apb(1'h1, `TCAP_OFS_COUNT, 32'h3);
    repeat (300) @(posedge core_clk);
    apb(1'h0, `TCAP_OFS_CTRL, 32'h0);
    chk(r, 32'h54);
    chk(timer_irq, 32'h1);
    apb(1'h1, `TCAP_OFS_GLOBAL, 32'h0);
    @(posedge core_clk);
    chk(timer_irq, 32'h0);
    apb(1'h1, `TCAP_OFS_GLOBAL, 32'h1);
    @(posedge core_clk);
    chk(timer_irq, 32'h1);
    lvl <= 1'b0;
    repeat (100) @(posedge core_clk);
    lvl <= 1'b1;
    repeat (100) @(posedge core_clk);
    apb(1'h0, `TCAP_OFS_CTRL, 32'h0);
    chk(r, 32'h5C);
    apb(1'h1, `TCAP_OFS_CTRL, 32'h54);
    apb(1'h0, `TCAP_OFS_CTRL, 32'h0);
    chk(r, 32'h54);
    apb(1'h1, `TCAP_OFS_CTRL, 32'h44);
    @(posedge core_clk);
    chk(timer_irq, 32'h0);
    apb(1'h0, `TCAP_OFS_CTRL, 32'h0);
    chk(r, 32'h44);
    $display("underflow done");
    apb(1'h1, `TCAP_OFS_CTRL, 32'h80);
    apb(1'h1, `TCAP_OFS_COUNT, 32'h20);
    repeat (300) @(posedge core_clk);
    apb(1'h0, `TCAP_OFS_COUNT, 32'h0);
    chk(r, 32'h20);
    apb(1'h1, `TCAP_OFS_CTRL, 32'h10);
    lvl <= 1'b0;
    repeat (100) @(posedge core_clk);
    lvl <= 1'b1;
    repeat (100) @(posedge core_clk);
    apb(1'h0, `TCAP_OFS_COUNT, 32'h0);
    chk(r, 32'h1F);
    $display("other modes done");
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'h0, `TCAP_OFS_CTRL, 32'h0);
    chk(r, 32'h0);
    apb(1'h0, `TCAP_OFS_COUNT, 32'h0);
    chk(r, 32'hFFFF);
    chk(timer_irq, 32'h0);
    $display("second reset done");
    wrap_up;
  end
endmodule
bind tcap_timer tcap_chk u_chk (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_pin(timer_pin), .timer_irq(timer_irq));
`default_nettype wire
